// ===== hw/dlca_link_cfg.v
// Data link configuration, mode decode and word ownership lookup.
// Assumes synchronous inputs, one clock, and a host that loads the
// parameter word and manual tables through the ports below.
//
// How it works
// - Node address comes from the front rotary switches, caught after reset.
// - Bits 5:4 select manual, core I/O only, data memory only, or both.
// - Bits 7:6 select 4/8, 8/16, 16/32 or 32/64 words per node.
// - Automatic mode uses fixed shared ranges, node 1 first from the base.
// - Automatic node count is 16, 8, 4 or 2 by block size.
// - Every automatic node gets the same number of words.
// - Manual entries carry separate sizes and starts anywhere in both areas.
// - Manual tables cover any subset of nodes 1 to 62.
// - Mode and layout come from the startup node's parameter word.
// - Links stay inactive while mode, tables or sizes are invalid.
// - Links run when the start bit is high, also if high at power-up.
// - Clearing the start bit halts the links.
// - Start bit is bit 0 of the link parameter control word.
// - Link areas must be contiguous; gaps between areas are rejected.
// - Manual tables are kept in the local table store as backup.
// - Older nodes' relay words 0-63 map to core I/O 1000-1063.
`timescale 1ns/1ps
`include "dlca_regs.vh"
module dlca_link_cfg #(
  parameter NODES = 62,
  parameter NAW = 6
) (
  input wire clk_i,
  input wire srst_i,
  input wire [NAW-1:0] node_sw_i,
  input wire startup_node_i,
  input wire [15:0] remote_param_i,
  input wire param_wr_i,
  input wire [15:0] param_wdata_i,
  output reg [15:0] param_rdata_o,
  input wire tbl_wr_i,
  input wire [NAW-1:0] tbl_node_i,
  input wire [44:0] tbl_wdata_i,
  input wire acc_req_i,
  input wire acc_area_i,
  input wire acc_legacy_i,
  input wire [14:0] acc_addr_i,
  input wire [NAW-1:0] acc_src_i,
  output reg acc_busy_o,
  output reg acc_done_o,
  output reg acc_hit_o,
  output reg acc_ok_o,
  output reg [NAW-1:0] acc_owner_o,
  output reg [NAW-1:0] node_addr_o,
  output reg [6:0] node_count_o,
  output reg cfg_err_o,
  output reg link_active_o
);
  localparam S_IDLE = 2'h0;
  localparam S_VAL = 2'h1;
  localparam S_LOOK = 2'h2;

  reg [1:0] state_r;
  reg [15:0] param_r;
  reg caught_r;
  reg dirty_r;
  reg man_ok_r;
  reg [NAW-1:0] idx_r;
  reg [NAW-1:0] idx_d_r;
  reg vld_d_r;
  reg scan_bad_r;
  reg loc_seen_r;
  reg cio_any_r;
  reg dm_any_r;
  reg [14:0] cio_next_r;
  reg [14:0] dm_next_r;
  reg pend_r;
  reg area_r;
  reg [14:0] addr_r;
  reg [NAW-1:0] src_r;
  reg legacy_bad_r;
  reg found_r;
  reg [NAW-1:0] found_node_r;
  wire [44:0] ent;
  wire [NAW-1:0] wr_idx;

  // ----------------------------------------------------------------
  // Effective configuration
  // ----------------------------------------------------------------
  wire [15:0] eff_param = startup_node_i ? param_r : remote_param_i;
  wire [1:0] mode = eff_param[`DLCA_PRM_MODE_MSB:`DLCA_PRM_MODE_LSB];
  wire [1:0] sel = eff_param[`DLCA_PRM_SIZE_MSB:`DLCA_PRM_SIZE_LSB];
  wire start_bit = eff_param[`DLCA_PRM_START_BIT];
  wire manual = (mode == `DLCA_MODE_MANUAL);
  wire use_cio = mode[0];
  wire use_dm = mode[1];
  wire [2:0] cio_sh = `DLCA_AUTO_CIO_SHIFT0 + {1'b0, sel};
  wire [2:0] dm_sh = `DLCA_AUTO_DM_SHIFT0 + {1'b0, sel};
  wire [6:0] auto_nodes = `DLCA_AUTO_NODES0 >> sel;
  wire node_ok = (node_addr_o != {NAW{1'b0}}) &&
    ({1'b0, node_addr_o} <= `DLCA_MAX_NODES);
  wire auto_ok = !manual && node_ok &&
    ({1'b0, node_addr_o} <= auto_nodes);
  wire cfg_ok = caught_r && (manual ? (man_ok_r && !dirty_r &&
    state_r != S_VAL && node_ok) : auto_ok);

  // Legacy relay words shift into the shared core I/O range
  wire legacy_bad = acc_legacy_i && !acc_area_i &&
    (acc_addr_i >= `DLCA_LEGACY_RELAY_WORDS);
  wire [14:0] req_addr = (acc_legacy_i && !acc_area_i) ?
    (acc_addr_i + `DLCA_AUTO_CIO_BASE) : acc_addr_i;

  // ----------------------------------------------------------------
  // Automatic ownership: equal blocks, node 1 at the base
  // ----------------------------------------------------------------
  wire [14:0] a_base = area_r ? `DLCA_AUTO_DM_BASE : `DLCA_AUTO_CIO_BASE;
  wire [14:0] a_words = area_r ? `DLCA_AUTO_DM_WORDS : `DLCA_AUTO_CIO_WORDS;
  wire [14:0] a_off = addr_r - a_base;
  wire [14:0] a_blk = a_off >> (area_r ? dm_sh : cio_sh);
  wire a_in = (addr_r >= a_base) && (a_off < a_words) &&
    (area_r ? use_dm : use_cio);
  wire [NAW-1:0] a_owner = a_blk[NAW-1:0] + {{(NAW-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // Manual entry fields as read from the table store
  // ----------------------------------------------------------------
  wire e_pres = ent[`DLCA_ENT_PRES];
  wire [14:0] e_cst = {2'h0, ent[`DLCA_ENT_CST_MSB:`DLCA_ENT_CST_LSB]};
  wire [14:0] e_csz = {7'h00, ent[`DLCA_ENT_CSZ_MSB:`DLCA_ENT_CSZ_LSB]};
  wire [14:0] e_dst = ent[`DLCA_ENT_DST_MSB:`DLCA_ENT_DST_LSB];
  wire [14:0] e_dsz = {7'h00, ent[`DLCA_ENT_DSZ_MSB:`DLCA_ENT_DSZ_LSB]};
  wire [15:0] e_cend = {1'b0, e_cst} + {1'b0, e_csz};
  wire [15:0] e_dend = {1'b0, e_dst} + {1'b0, e_dsz};
  wire [NAW-1:0] e_node = idx_d_r + {{(NAW-1){1'b0}}, 1'b1};
  // Size limit and area end; start anywhere inside each area
  wire e_range_bad = (e_csz[7:0] > `DLCA_MAN_SIZE_MAX) ||
    (e_dsz[7:0] > `DLCA_MAN_SIZE_MAX) ||
    (e_cend > {1'b0, `DLCA_MAN_CIO_LAST} + 16'h0001) ||
    (e_dend > {1'b0, `DLCA_MAN_DM_LAST} + 16'h0001);
  // Each present entry with a nonzero size must start where the previous sized one ended
  wire e_gap = (cio_any_r && e_csz != 15'h0000 && e_cst != cio_next_r) ||
    (dm_any_r && e_dsz != 15'h0000 && e_dst != dm_next_r);
  wire e_hit = e_pres && (area_r ?
    (addr_r >= e_dst && {1'b0, addr_r} < e_dend) :
    (addr_r >= e_cst && {1'b0, addr_r} < e_cend));
  wire scan_last = vld_d_r && ({1'b0, idx_d_r} == NODES[6:0] - 7'h01);
  wire scanning = (state_r == S_VAL) || (state_r == S_LOOK);
  assign wr_idx = tbl_node_i - {{(NAW-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------
  // Table store, also the backup copy of the manual tables
  // ----------------------------------------------------------------
  dlca_table_mem #(
    .WIDTH(`DLCA_ENT_W),
    .DEPTH(NODES),
    .AW(NAW)
  ) u_tbl (
    .clk_i(clk_i),
    .wr_en_i(tbl_wr_i && tbl_node_i != {NAW{1'b0}} &&
      {1'b0, tbl_node_i} <= NODES[6:0]),
    .wr_addr_i(wr_idx),
    .wr_data_i(tbl_wdata_i),
    .rd_addr_i(idx_r),
    .rd_data_o(ent)
  );

  // ----------------------------------------------------------------
  // Parameter word, node address capture, link run control
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (srst_i) begin
      param_r <= `DLCA_PRM_RESET;
      caught_r <= 1'b0;
      node_addr_o <= {NAW{1'b0}};
      link_active_o <= 1'b0;
      cfg_err_o <= 1'b0;
      node_count_o <= 7'h00;
      param_rdata_o <= `DLCA_PRM_RESET;
    end else begin
      if (param_wr_i) begin
        param_r <= param_wdata_i;
      end
      // Switches are read once after reset; changes need a restart
      if (!caught_r) begin
        node_addr_o <= node_sw_i;
        caught_r <= 1'b1;
      end
      // Level run: a bit already high at power-up also starts
      link_active_o <= start_bit && cfg_ok;
      cfg_err_o <= caught_r && !cfg_ok;
      node_count_o <= manual ? 7'h00 : auto_nodes;
      param_rdata_o <= param_r;
    end
  end

  // ----------------------------------------------------------------
  // Scan engine: table validation and manual ownership lookup
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= S_IDLE;
      dirty_r <= 1'b1;
      man_ok_r <= 1'b0;
      idx_r <= {NAW{1'b0}};
      idx_d_r <= {NAW{1'b0}};
      vld_d_r <= 1'b0;
      scan_bad_r <= 1'b0;
      loc_seen_r <= 1'b0;
      cio_any_r <= 1'b0;
      dm_any_r <= 1'b0;
      cio_next_r <= 15'h0000;
      dm_next_r <= 15'h0000;
      pend_r <= 1'b0;
      area_r <= 1'b0;
      addr_r <= 15'h0000;
      src_r <= {NAW{1'b0}};
      legacy_bad_r <= 1'b0;
      found_r <= 1'b0;
      found_node_r <= {NAW{1'b0}};
      acc_busy_o <= 1'b0;
      acc_done_o <= 1'b0;
      acc_hit_o <= 1'b0;
      acc_ok_o <= 1'b0;
      acc_owner_o <= {NAW{1'b0}};
    end else begin
      acc_done_o <= 1'b0;
      // A table write during a scan marks it stale again; set wins
      if (tbl_wr_i) begin
        dirty_r <= 1'b1;
      end
      // One query held at a time; others refused while busy
      if (acc_req_i && !pend_r) begin
        pend_r <= 1'b1;
        area_r <= acc_area_i;
        addr_r <= req_addr;
        src_r <= acc_src_i;
        legacy_bad_r <= legacy_bad;
      end
      acc_busy_o <= pend_r || (acc_req_i && !pend_r);
      vld_d_r <= scanning && !scan_last;
      idx_d_r <= idx_r;
      if (scanning && !scan_last) begin
        idx_r <= idx_r + {{(NAW-1){1'b0}}, 1'b1};
      end
      case (state_r)
        S_IDLE: begin
          idx_r <= {NAW{1'b0}};
          vld_d_r <= 1'b0;
          if (dirty_r && !tbl_wr_i) begin
            dirty_r <= 1'b0;
            scan_bad_r <= 1'b0;
            loc_seen_r <= 1'b0;
            cio_any_r <= 1'b0;
            dm_any_r <= 1'b0;
            state_r <= S_VAL;
          end else if (pend_r && (!manual || legacy_bad_r)) begin
            // Automatic answer: one cycle, no table access
            pend_r <= 1'b0;
            acc_done_o <= 1'b1;
            acc_hit_o <= a_in && !legacy_bad_r && !manual;
            acc_owner_o <= a_in ? a_owner : {NAW{1'b0}};
            acc_ok_o <= link_active_o && a_in && !legacy_bad_r &&
              !manual && a_owner == src_r;
          end else if (pend_r) begin
            found_r <= 1'b0;
            state_r <= S_LOOK;
          end
        end
        S_VAL: begin
          if (vld_d_r && e_pres) begin
            if (e_range_bad || e_gap) begin
              scan_bad_r <= 1'b1;
            end
            if (e_node == node_addr_o) begin
              loc_seen_r <= 1'b1;
            end
            if (e_csz != 15'h0000) begin
              cio_any_r <= 1'b1;
              cio_next_r <= e_cend[14:0];
            end
            if (e_dsz != 15'h0000) begin
              dm_any_r <= 1'b1;
              dm_next_r <= e_dend[14:0];
            end
          end
          if (scan_last) begin
            man_ok_r <= !scan_bad_r && !(vld_d_r && e_pres &&
              (e_range_bad || e_gap)) && (loc_seen_r ||
              (e_pres && e_node == node_addr_o));
            state_r <= S_IDLE;
          end
        end
        S_LOOK: begin
          // First matching node in order owns the word
          if (vld_d_r && e_hit && !found_r) begin
            found_r <= 1'b1;
            found_node_r <= e_node;
          end
          if (scan_last) begin
            pend_r <= 1'b0;
            acc_done_o <= 1'b1;
            acc_hit_o <= found_r || e_hit;
            acc_owner_o <= found_r ? found_node_r :
              (e_hit ? e_node : {NAW{1'b0}});
            acc_ok_o <= link_active_o && ((found_r &&
              found_node_r == src_r) || (!found_r && e_hit &&
              e_node == src_r));
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // dlca_link_cfg

// ===== hw/dlca_regs.vh
// Constants for the data link configuration and allocation block.
// Included by dlca_link_cfg by bare name; definitions only.
`ifndef DLCA_REGS_VH
`define DLCA_REGS_VH

// ----------------------------------------------------------------
// Link parameter control word fields
// ----------------------------------------------------------------
`define DLCA_PRM_START_BIT 0
`define DLCA_PRM_MODE_LSB 4
`define DLCA_PRM_MODE_MSB 5
`define DLCA_PRM_SIZE_LSB 6
`define DLCA_PRM_SIZE_MSB 7
`define DLCA_PRM_RESET 16'h0000

// Link mode codes (bit 5, bit 4)
`define DLCA_MODE_MANUAL 2'h0
`define DLCA_MODE_CIO 2'h1
`define DLCA_MODE_DM 2'h2
`define DLCA_MODE_BOTH 2'h3

// ----------------------------------------------------------------
// Automatic shared areas
// ----------------------------------------------------------------
`define DLCA_AUTO_CIO_BASE 15'h03e8
`define DLCA_AUTO_CIO_WORDS 15'h0040
`define DLCA_AUTO_DM_BASE 15'h0000
`define DLCA_AUTO_DM_WORDS 15'h0080
`define DLCA_AUTO_CIO_SHIFT0 3'h2
`define DLCA_AUTO_DM_SHIFT0 3'h3
`define DLCA_AUTO_NODES0 7'h10
`define DLCA_LEGACY_RELAY_WORDS 15'h0040

// ----------------------------------------------------------------
// Manual area limits
// ----------------------------------------------------------------
`define DLCA_MAN_CIO_LAST 15'h17ff
`define DLCA_MAN_DM_LAST 15'h7fff
`define DLCA_MAN_SIZE_MAX 8'hfe
`define DLCA_MAX_NODES 7'h3e

// Table entry layout: present, cio start, cio size, dm start, dm size
`define DLCA_ENT_W 45
`define DLCA_ENT_PRES 44
`define DLCA_ENT_CST_MSB 43
`define DLCA_ENT_CST_LSB 31
`define DLCA_ENT_CSZ_MSB 30
`define DLCA_ENT_CSZ_LSB 23
`define DLCA_ENT_DST_MSB 22
`define DLCA_ENT_DST_LSB 8
`define DLCA_ENT_DSZ_MSB 7
`define DLCA_ENT_DSZ_LSB 0

`endif

// ===== hw/dlca_table_mem.v
// Manual link table store, one entry per network node.
// Assumes one clock; read data come from a register one edge later.
`timescale 1ns/1ps
module dlca_table_mem #(
  parameter WIDTH = 45,
  parameter DEPTH = 62,
  parameter AW = 6
) (
  input wire clk_i,
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire [AW-1:0] rd_addr_i,
  output reg [WIDTH-1:0] rd_data_o
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  integer i;

  // No reset on the array; contents start cleared, then host writes
  initial begin
    for (i = 0; i < DEPTH; i = i + 1) begin
      mem_r[i] = {WIDTH{1'b0}};
    end
  end

  // Write port and registered read port
  always @(posedge clk_i) begin
    if (wr_en_i) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem_r[rd_addr_i];
  end
endmodule // dlca_table_mem

// ===== tb/dlca_cfg_sva.sv
// Checker for the link configuration block, ports only.
// Bound onto dlca_link_cfg from the bench top file; one clock.
`timescale 1ns/1ps
module dlca_cfg_sva #(
  parameter NAW = 6
) (
  input wire clk_i,
  input wire srst_i,
  input wire [NAW-1:0] node_sw_i,
  input wire startup_node_i,
  input wire param_wr_i,
  input wire [15:0] param_wdata_i,
  input wire [15:0] param_rdata_o,
  input wire acc_req_i,
  input wire acc_busy_o,
  input wire acc_done_o,
  input wire acc_hit_o,
  input wire acc_ok_o,
  input wire [NAW-1:0] acc_owner_o,
  input wire [NAW-1:0] node_addr_o,
  input wire [6:0] node_count_o,
  input wire cfg_err_o,
  input wire link_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ----------------------------------------
  // Query handshake steps
  // ----------------------------------------
  sequence s_take;
    acc_req_i && !acc_busy_o;
  endsequence
  sequence s_answer;
    acc_busy_o ##[0:200] acc_done_o;
  endsequence
  property p_query;
    s_take |=> s_answer;
  endproperty
  a_query: assert property (p_query)
    else $error("query not answered in time");
  property p_pulse;
    acc_done_o |=> !acc_done_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("answer strobe longer than one cycle");
  property p_ok;
    acc_done_o && acc_ok_o |-> acc_hit_o && $past(link_active_o) &&
      acc_owner_o != 0;
  endproperty
  a_ok: assert property (p_ok)
    else $error("write allowed on idle link or unowned word");
  // ----------------------------------------
  // Mode, count and start control
  // ----------------------------------------
  property p_count;
    logic [1:0] sel;
    (param_wr_i && startup_node_i && param_wdata_i[5:4] != 2'h0,
      sel = param_wdata_i[7:6]) ##1 (!param_wr_i && startup_node_i) [*2]
      |-> node_count_o == (7'h10 >> sel);
  endproperty
  a_count: assert property (p_count)
    else $error("automatic node count wrong");
  property p_stop;
    param_wr_i && startup_node_i && !param_wdata_i[0] |=> ##1
      !link_active_o;
  endproperty
  a_stop: assert property (p_stop)
    else $error("link still active after stop");
  property p_start;
    link_active_o && startup_node_i && $past(startup_node_i, 2)
      |-> param_rdata_o[0];
  endproperty
  a_start: assert property (p_start)
    else $error("link active without start bit");
  property p_valid;
    link_active_o |-> !cfg_err_o;
  endproperty
  a_valid: assert property (p_valid)
    else $error("link active with invalid settings");
  property p_addr;
    $fell(srst_i) |-> ##[1:3] node_addr_o == $past(node_sw_i);
  endproperty
  a_addr: assert property (p_addr)
    else $error("node address not taken from switches");
endmodule // dlca_cfg_sva

// ===== tb/dlca_peer.sv
// Model of the startup node whose word governs the link.
// Loaded by hierarchical task call from the bench; one clock.
`timescale 1ns/1ps
module dlca_peer (
  input wire clk_i,
  output reg [15:0] param_o
);
  initial param_o = 16'h0000;
  // Host load of the startup word, changed just after an edge
  task load(input [15:0] w);
    @(posedge clk_i);
    #1 param_o = w;
  endtask
endmodule // dlca_peer

// ===== tb/test_dlca_link_cfg.sv
// Bench for the link configuration block: auto, manual, start/stop.
// Assumes the design files under hw/ and dlca_peer are compiled first.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  fails++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_dlca_link_cfg;
  reg clk_i, srst_i, startup_node_i, param_wr_i, tbl_wr_i, acc_req_i;
  reg acc_area_i, acc_legacy_i;
  reg [5:0] node_sw_i, tbl_node_i, acc_src_i;
  reg [15:0] param_wdata_i;
  reg [44:0] tbl_wdata_i;
  reg [14:0] acc_addr_i;
  wire [15:0] remote_param_i, param_rdata_o;
  wire acc_busy_o, acc_done_o, acc_hit_o, acc_ok_o, cfg_err_o;
  wire link_active_o;
  wire [5:0] acc_owner_o, node_addr_o;
  wire [6:0] node_count_o;
  integer fails = 0;
  integer comparisons = 0;
  dlca_link_cfg dlca_link_cfg_i (.clk_i, .srst_i, .node_sw_i,
    .startup_node_i, .remote_param_i, .param_wr_i, .param_wdata_i,
    .param_rdata_o, .tbl_wr_i, .tbl_node_i, .tbl_wdata_i, .acc_req_i,
    .acc_area_i, .acc_legacy_i, .acc_addr_i, .acc_src_i, .acc_busy_o,
    .acc_done_o, .acc_hit_o, .acc_ok_o, .acc_owner_o, .node_addr_o,
    .node_count_o, .cfg_err_o, .link_active_o);
  dlca_peer dlca_peer_i (.clk_i, .param_o(remote_param_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task wr_param(input [15:0] w);
    @(posedge clk_i);
    #1 param_wr_i = 1'b1;
    param_wdata_i = w;
    @(posedge clk_i);
    #1 param_wr_i = 1'b0;
    repeat (2) @(posedge clk_i);
    `CHK(param_rdata_o, w)
  endtask
  task wr_tbl(input [5:0] n, input [44:0] e);
    @(posedge clk_i);
    #1 tbl_wr_i = 1'b1;
    tbl_node_i = n;
    tbl_wdata_i = e;
    @(posedge clk_i);
    #1 tbl_wr_i = 1'b0;
  endtask
  // Query one word; hit is expected wherever an owner is
  task qchk(input ar, input lg, input [14:0] a, input [5:0] s,
    input [5:0] own, input ok);
    integer k;
    @(posedge clk_i);
    #1 acc_req_i = 1'b1;
    acc_area_i = ar;
    acc_legacy_i = lg;
    acc_addr_i = a;
    acc_src_i = s;
    @(posedge clk_i);
    #1 acc_req_i = 1'b0;
    k = 0;
    while (acc_done_o !== 1'b1 && k < 300) begin
      @(posedge clk_i);
      #1 k = k + 1;
    end
    `CHK(k < 300, 1'b1)
    `CHK(acc_owner_o, own)
    `CHK(acc_hit_o, own != 6'h00)
    `CHK(acc_ok_o, ok)
    @(posedge clk_i);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_auto;
    integer s;
    reg [5:0] last;
    for (s = 0; s < 4; s = s + 1) begin
      wr_param({8'h00, s[1:0], 6'h31});
      last = 6'h10 >> s;
      `CHK(node_count_o, 7'h10 >> s)
      `CHK(link_active_o, 1'b1)
      qchk(1'b0, 1'b0, 15'd1000 + (15'd4 << s), 6'h02, 6'h02, 1'b1);
      qchk(1'b1, 1'b0, 15'd127, 6'h01, last, 1'b0);
      qchk(1'b0, 1'b1, 15'd63, last, last, 1'b1);
    end
    qchk(1'b0, 1'b0, 15'd999, 6'h01, 6'h00, 1'b0);
    $display("test auto done");
  endtask
  task t_modes;
    integer m;
    for (m = 1; m < 3; m = m + 1) begin
      wr_param({10'h000, m[1:0], 4'h1});
      qchk(1'b0, 1'b0, 15'd1000, 6'h01, {5'h00, m[0]}, m[0]);
      qchk(1'b1, 1'b0, 15'd0, 6'h01, {5'h00, m[1]}, m[1]);
    end
    wr_param(16'h0030);
    `CHK(link_active_o, 1'b0)
    qchk(1'b0, 1'b0, 15'd1000, 6'h01, 6'h01, 1'b0);
    $display("test modes done");
  endtask
  task t_manual;
    wr_param(16'h0001);
    repeat (70) @(posedge clk_i);
    `CHK(link_active_o, 1'b0)
    // Non-participating node holds no table before the start
    wr_tbl(6'h03, 45'h0);
    wr_tbl(6'h01, {1'b1, 13'd0, 8'd10, 15'd0, 8'd0});
    wr_tbl(6'h02, {1'b1, 13'd10, 8'd5, 15'd0, 8'd0});
    repeat (140) @(posedge clk_i);
    `CHK(cfg_err_o, 1'b0)
    `CHK(link_active_o, 1'b1)
    `CHK(node_count_o, 7'h00)
    qchk(1'b0, 1'b0, 15'd12, 6'h02, 6'h02, 1'b1);
    wr_tbl(6'h02, {1'b1, 13'd11, 8'd5, 15'd0, 8'd0});
    repeat (140) @(posedge clk_i);
    `CHK(cfg_err_o, 1'b1)
    `CHK(link_active_o, 1'b0)
    $display("test manual done");
  endtask
  task t_remote;
    wr_param(16'h0031);
    dlca_peer_i.load(16'h0030);
    #1 startup_node_i = 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK(link_active_o, 1'b0)
    dlca_peer_i.load(16'h0031);
    repeat (4) @(posedge clk_i);
    `CHK(link_active_o, 1'b1)
    #1 startup_node_i = 1'b1;
    $display("test remote done");
  endtask
  task print_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Tests need about 600 cycles; allow well over fifty times that
  initial begin
    #2000000;
    fails++;
    print_verdict;
  end
  initial begin
    srst_i = 1'b1;
    startup_node_i = 1'b1;
    node_sw_i = 6'h01;
    {param_wr_i, tbl_wr_i, acc_req_i, acc_area_i, acc_legacy_i} = 5'h00;
    {tbl_node_i, acc_src_i, param_wdata_i} = 28'h0000000;
    tbl_wdata_i = 45'h0;
    acc_addr_i = 15'h0000;
    repeat (12) @(posedge clk_i);
    #1 srst_i = 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK(node_addr_o, 6'h01)
    `CHK(param_rdata_o, 16'h0000)
    t_auto;
    t_modes;
    t_manual;
    t_remote;
    print_verdict;
  end
endmodule // test_dlca_link_cfg
bind dlca_link_cfg dlca_cfg_sva #(.NAW(6)) dlca_cfg_sva_i (.clk_i, .srst_i,
  .node_sw_i, .startup_node_i, .param_wr_i, .param_wdata_i, .param_rdata_o,
  .acc_req_i, .acc_busy_o, .acc_done_o, .acc_hit_o, .acc_ok_o, .acc_owner_o,
  .node_addr_o, .node_count_o, .cfg_err_o, .link_active_o);
